// >>> logic/les_fall.sv
// Falling edge detector giving a one-cycle pulse when a level drops.
`timescale 1ns/10ps
module les_fall (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic level,
   output logic fall
);
   logic prev_q;
   logic prev_d;

   always_comb begin
      prev_d = level;
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= prev_d;
      end
   end

   assign fall = prev_q & ~level;
endmodule : les_fall

// >>> logic/les_flag.sv
// Sticky flags that hardware sets and a shared clear removes; set wins over clear.
`timescale 1ns/10ps
module les_flag #(
   parameter int W = 1
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [W-1:0] set,
   input wire logic clear,
   output logic [W-1:0] flag_q
);
   logic [W-1:0] flag_d;

   // An event in the clearing cycle survives so no end-of-program is lost.
   always_comb begin
      flag_d = set | (clear ? '0 : flag_q);
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         flag_q <= '0;
      end else begin
         flag_q <= flag_d;
      end
   end
endmodule : les_flag

// >>> logic/les_regs.sv
// Engine start, LED test, pump control and engine status registers with the interrupt pin.
`timescale 1ns/10ps
module les_regs (
   input wire logic clock,
   input wire logic sys_rst,
   input wire les_pkg::les_req_type req,
   input wire les_pkg::les_core_type core,
   input wire logic [1:0] pin_config,
   output logic [7:0] rdata_q,
   output logic rvalid_q,
   output logic [7:0] engine_one_start_address,
   output logic [7:0] engine_two_start_address,
   output logic [7:0] engine_three_start_address,
   output logic short_test_en_q,
   output logic open_test_en_q,
   output les_pkg::les_headroom_type headroom_q,
   output logic pump_discharge_q,
   output logic int_pin_n_q,
   output logic int_pin_oe_q
);
   logic [7:0] start_q [les_pkg::NUM_ENGINES];
   logic [7:0] start_d [les_pkg::NUM_ENGINES];
   logic [7:0] test_pump_q;
   logic [7:0] test_pump_d;
   logic mask_q;
   logic mask_d;
   logic [7:0] rdata_d;
   logic rvalid_d;
   les_pkg::les_headroom_type headroom_d;
   logic short_d;
   logic open_d;
   logic discharge_d;
   logic int_n_d;
   logic int_oe_d;
   logic any_busy;
   logic busy_fall;
   logic status_read;
   logic [2:0] eng_flag;
   logic busy_done;
   logic [7:0] status_view;

   assign any_busy = core.startup_running | (|core.engine_clearing);
   assign status_read = req.rd && (req.addr == les_pkg::ADDR_STATE_FLAGS);

   // Engine end or interrupt instruction sets the per-engine flag.
   les_flag #(
      .W(3)
   ) u_eng_flags (
      .clock(clock),
      .sys_rst(sys_rst),
      .set(core.engine_irq_event),
      .clear(status_read),
      .flag_q(eng_flag)
   );

   les_fall u_busy_fall (
      .clock(clock),
      .sys_rst(sys_rst),
      .level(any_busy),
      .fall(busy_fall)
   );

   // Masked busy endings are dropped rather than held, so unmasking later fires nothing stale.
   les_flag #(
      .W(1)
   ) u_busy_done (
      .clock(clock),
      .sys_rst(sys_rst),
      .set(busy_fall && !mask_q),
      .clear(status_read),
      .flag_q(busy_done)
   );

   // Busy bits are live levels; reserved bits stay zero.
   always_comb begin
      status_view = 8'h00;
      status_view[les_pkg::BIT_MASK_BUSY] = mask_q;
      status_view[les_pkg::BIT_STARTUP_BUSY] = core.startup_running;
      status_view[les_pkg::BIT_ENGINE_BUSY] = |core.engine_clearing;
      status_view[2:0] = eng_flag;
   end

   // Register writes; the engine busy restriction is left to the host.
   always_comb begin
      for (int i = 0; i < les_pkg::NUM_ENGINES; i++) begin
         start_d[i] = start_q[i];
      end
      test_pump_d = test_pump_q;
      mask_d = mask_q;
      if (req.wr) begin
         if (req.addr == les_pkg::ADDR_ENG_ONE_START) begin
            start_d[0] = req.wdata;
         end else if (req.addr == les_pkg::ADDR_ENG_TWO_START) begin
            start_d[1] = req.wdata;
         end else if (req.addr == les_pkg::ADDR_ENG_THREE_START) begin
            start_d[2] = req.wdata;
         end else if (req.addr == les_pkg::ADDR_TEST_PUMP) begin
            test_pump_d = req.wdata;
         end else if (req.addr == les_pkg::ADDR_STATE_FLAGS) begin
            mask_d = req.wdata[les_pkg::BIT_MASK_BUSY];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         for (int i = 0; i < les_pkg::NUM_ENGINES; i++) begin
            start_q[i] <= les_pkg::RST_START_ADDRESS;
         end
         test_pump_q <= les_pkg::RST_TEST_PUMP;
         mask_q <= les_pkg::RST_STATE_FLAGS[les_pkg::BIT_MASK_BUSY];
      end else begin
         for (int i = 0; i < les_pkg::NUM_ENGINES; i++) begin
            start_q[i] <= start_d[i];
         end
         test_pump_q <= test_pump_d;
         mask_q <= mask_d;
      end
   end

   assign engine_one_start_address = start_q[0];
   assign engine_two_start_address = start_q[1];
   assign engine_three_start_address = start_q[2];

   // Read data one cycle after the request; unmapped offsets answer zero.
   always_comb begin
      rvalid_d = req.rd;
      rdata_d = les_pkg::READ_UNMAPPED;
      if (req.rd) begin
         if (req.addr == les_pkg::ADDR_ENG_ONE_START) begin
            rdata_d = start_q[0];
         end else if (req.addr == les_pkg::ADDR_ENG_TWO_START) begin
            rdata_d = start_q[1];
         end else if (req.addr == les_pkg::ADDR_ENG_THREE_START) begin
            rdata_d = start_q[2];
         end else if (req.addr == les_pkg::ADDR_TEST_PUMP) begin
            rdata_d = test_pump_q;
         end else if (req.addr == les_pkg::ADDR_STATE_FLAGS) begin
            rdata_d = status_view;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   // Analog controls decoded from the test and pump register.
   always_comb begin
      short_d = test_pump_q[les_pkg::BIT_SHORT_TEST];
      open_d = test_pump_q[les_pkg::BIT_OPEN_TEST];
      case (test_pump_q[les_pkg::BIT_HEADROOM_HI:les_pkg::BIT_HEADROOM_LO])
         les_pkg::HR_CODE_200: headroom_d = les_pkg::hr_200mv;
         les_pkg::HR_CODE_300: headroom_d = les_pkg::hr_300mv;
         default: headroom_d = les_pkg::hr_250mv;
      endcase
      discharge_d = !test_pump_q[les_pkg::BIT_DISCHARGE_DIS] && core.low_power_state
         && !core.thermal_shutdown;
   end

   // Pin low is the asserted level; it is driven only when pin_config selects the interrupt function.
   always_comb begin
      int_n_d = !((|eng_flag) || busy_done);
      int_oe_d = (pin_config == les_pkg::PIN_CFG_IRQ);
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         short_test_en_q <= 1'b0;
         open_test_en_q <= 1'b0;
         headroom_q <= les_pkg::hr_250mv;
         pump_discharge_q <= 1'b0;
         int_pin_n_q <= 1'b1;
         int_pin_oe_q <= 1'b0;
      end else begin
         short_test_en_q <= short_d;
         open_test_en_q <= open_d;
         headroom_q <= headroom_d;
         pump_discharge_q <= discharge_d;
         int_pin_n_q <= int_n_d;
         int_pin_oe_q <= int_oe_d;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   start_addr_write_a: assert property (
      (req.wr && req.addr == les_pkg::ADDR_ENG_TWO_START)
      |=> engine_two_start_address == $past(req.wdata))
      else $error("Engine two start address did not take the write.");

   short_test_out_a: assert property (
      (req.wr && req.addr == les_pkg::ADDR_TEST_PUMP)
      |=> ##1 short_test_en_q == $past(req.wdata[4], 2))
      else $error("Short test enable does not follow bit 4.");

   open_test_out_a: assert property (
      (req.wr && req.addr == les_pkg::ADDR_TEST_PUMP)
      |=> ##1 open_test_en_q == $past(req.wdata[3], 2))
      else $error("Open test enable does not follow bit 3.");

   headroom_decode_a: assert property (
      (test_pump_q[2:1] == 2'h3 |=> headroom_q == les_pkg::hr_250mv)
      and (test_pump_q[2:1] == 2'h1 |=> headroom_q == les_pkg::hr_250mv)
      and (test_pump_q[2:1] == 2'h2 |=> headroom_q == les_pkg::hr_300mv)
      and (test_pump_q[2:1] == 2'h0 |=> headroom_q == les_pkg::hr_200mv))
      else $error("Headroom threshold decoded wrongly.");

   pump_discharge_a: assert property (
      (core.thermal_shutdown || test_pump_q[0]) |=> !pump_discharge_q)
      else $error("Pump discharged while disabled or in thermal shutdown.");

   busy_mask_a: assert property (
      (busy_fall && !mask_q && !status_read) |=> ##1 !int_pin_n_q)
      else $error("Unmasked busy end raised no interrupt.");

   read_release_a: assert property (
      (status_read && core.engine_irq_event == 3'h0 && !busy_fall) |=> ##1 int_pin_n_q)
      else $error("Status read did not release the interrupt pin.");

   startup_bit_a: assert property (
      status_read |=> rdata_q[6] == $past(core.startup_running))
      else $error("Startup busy bit wrong on read.");

   engine_busy_bit_a: assert property (
      status_read |=> rdata_q[5] == $past(|core.engine_clearing))
      else $error("Engine busy bit wrong on read.");

   engine_flag_set_a: assert property (
      core.engine_irq_event[0] |=> eng_flag[0] ##1 !int_pin_n_q)
      else $error("Engine one flag not set by its event.");

   reserved_zero_a: assert property (
      status_read |=> rdata_q[4:3] == 2'h0)
      else $error("Reserved status bits read nonzero.");

   flag_write_ignored_a: assert property (
      (req.wr && !req.rd && core.engine_irq_event == 3'h0)
      |=> eng_flag == $past(eng_flag)
         && ($past(req.addr) != les_pkg::ADDR_STATE_FLAGS
            || mask_q == $past(req.wdata[les_pkg::BIT_MASK_BUSY])))
      else $error("Host write altered engine flags.");
endmodule : les_regs

// >>> pkg/les_pkg.sv
// Package with offsets, field positions, reset values and carrier types of the LED status registers.
package les_pkg;
   localparam logic [7:0] ADDR_ENG_ONE_START = 8'h30;
   localparam logic [7:0] ADDR_ENG_TWO_START = 8'h31;
   localparam logic [7:0] ADDR_ENG_THREE_START = 8'h32;
   localparam logic [7:0] ADDR_TEST_PUMP = 8'h33;
   localparam logic [7:0] ADDR_STATE_FLAGS = 8'h3c;
   localparam logic [7:0] RST_START_ADDRESS = 8'h00;
   localparam logic [7:0] RST_TEST_PUMP = 8'h02;
   localparam logic [7:0] RST_STATE_FLAGS = 8'h80;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   localparam int BIT_SHORT_TEST = 4;
   localparam int BIT_OPEN_TEST = 3;
   localparam int BIT_HEADROOM_HI = 2;
   localparam int BIT_HEADROOM_LO = 1;
   localparam int BIT_DISCHARGE_DIS = 0;
   localparam int BIT_MASK_BUSY = 7;
   localparam int BIT_STARTUP_BUSY = 6;
   localparam int BIT_ENGINE_BUSY = 5;
   localparam int NUM_ENGINES = 3;
   localparam logic [1:0] HR_CODE_200 = 2'h0;
   localparam logic [1:0] HR_CODE_300 = 2'h2;
   localparam logic [1:0] PIN_CFG_IRQ = 2'h1;

   typedef enum logic [1:0] {
      hr_200mv,
      hr_250mv,
      hr_300mv
   } les_headroom_type;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } les_req_type;

   typedef struct packed {
      logic startup_running;
      logic [2:0] engine_clearing;
      logic [2:0] engine_irq_event;
      logic thermal_shutdown;
      logic low_power_state;
   } les_core_type;
endpackage : les_pkg

// >>> tb/led_engine_status_regs_test.sv
// Self-checking bench for the engine status and LED control registers.
`timescale 1ns/10ps
module led_engine_status_regs_test;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   les_pkg::les_req_type req;
   les_pkg::les_core_type core = '0;
   logic [1:0] pin_config = 2'h1;
   logic [7:0] rdata_q, a1, a2, a3;
   logic rvalid_q, st, ot, pd, irq_n, irq_oe;
   les_pkg::les_headroom_type hr;
   int mismatches = 0;
   int cmp_count = 0;
   int cycles = 0;
   always #25 clock = ~clock;
   les_regs dut (.clock(clock), .sys_rst(sys_rst), .req(req), .core(core),
      .pin_config(pin_config), .rdata_q(rdata_q), .rvalid_q(rvalid_q),
      .engine_one_start_address(a1), .engine_two_start_address(a2),
      .engine_three_start_address(a3), .short_test_en_q(st), .open_test_en_q(ot),
      .headroom_q(hr), .pump_discharge_q(pd), .int_pin_n_q(irq_n), .int_pin_oe_q(irq_oe));
   les_host host (.clock(clock), .engine_busy(|core.engine_clearing), .rdata_q(rdata_q),
      .rvalid_q(rvalid_q), .req(req));
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : conclude
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: byte %h expected %h", $time, got, exp);
      end
   endtask : chk_byte
   task automatic chk_bit(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: bit %b expected %b", $time, got, exp);
      end
   endtask : chk_bit
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      logic v;
      host.access(1'b1, a, d, q, v);
      chk_bit(v, 1'b0);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] q;
      logic v;
      host.access(1'b0, a, 8'h00, q, v);
      chk_bit(v, 1'b1);
      chk_byte(q, exp);
   endtask : rd
   // A hang costs a mismatch rather than an endless run.
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         mismatches++;
         conclude();
      end
   end
   initial begin
      tick(6);
      sys_rst = 1'b0;
      chk_bit(irq_n, 1'b1);
      rd(8'h30, 8'h00);
      rd(8'h31, 8'h00);
      rd(8'h32, 8'h00);
      rd(8'h33, 8'h02);
      rd(8'h3c, 8'h80);
      rd(8'h3d, 8'h00);
      chk_byte({6'h0, hr}, 8'h01);
      chk_bit(irq_oe, 1'b1);
      wr(8'h30, 8'h5a);
      wr(8'h31, 8'ha5);
      wr(8'h32, 8'hff);
      rd(8'h30, 8'h5a);
      rd(8'h31, 8'ha5);
      rd(8'h32, 8'hff);
      chk_byte(a1, 8'h5a);
      chk_byte(a2, 8'ha5);
      chk_byte(a3, 8'hff);
      core.low_power_state = 1'b1;
      for (int i = 0; i < 32; i++) begin
         wr(8'h33, 8'(i));
         tick(1);
         chk_bit(st, i[4]);
         chk_bit(ot, i[3]);
         chk_byte({6'h0, hr}, i[2:1] == 0 ? 8'h00 : (i[2:1] == 2 ? 8'h02 : 8'h01));
         chk_bit(pd, !i[0]);
      end
      core.thermal_shutdown = 1'b1;
      wr(8'h33, 8'h00);
      tick(1);
      chk_bit(pd, 1'b0);
      core.thermal_shutdown = 1'b0;
      tick(2);
      chk_bit(pd, 1'b1);
      core.low_power_state = 1'b0;
      tick(2);
      chk_bit(pd, 1'b0);
      for (int e = 0; e < 3; e++) begin
         core.engine_irq_event = 3'(1 << e);
         tick(1);
         core.engine_irq_event = 3'h0;
         tick(2);
         chk_bit(irq_n, 1'b0);
         rd(8'h3c, 8'h80 | 8'(1 << e));
         tick(1);
         chk_bit(irq_n, 1'b1);
         rd(8'h3c, 8'h80);
      end
      core.engine_irq_event = 3'h2;
      tick(1);
      core.engine_irq_event = 3'h0;
      wr(8'h3c, 8'h7f);
      rd(8'h3c, 8'h02);
      rd(8'h3c, 8'h00);
      core.startup_running = 1'b1;
      core.engine_clearing = 3'h4;
      tick(1);
      rd(8'h3c, 8'h60);
      chk_bit(irq_n, 1'b1);
      core.startup_running = 1'b0;
      core.engine_clearing = 3'h0;
      tick(4);
      chk_bit(irq_n, 1'b0);
      rd(8'h3c, 8'h00);
      tick(1);
      chk_bit(irq_n, 1'b1);
      wr(8'h3c, 8'h80);
      core.engine_clearing = 3'h1;
      tick(2);
      core.engine_clearing = 3'h0;
      tick(4);
      chk_bit(irq_n, 1'b1);
      rd(8'h3c, 8'h80);
      sys_rst = 1'b1;
      tick(2);
      sys_rst = 1'b0;
      chk_bit(irq_n, 1'b1);
      rd(8'h30, 8'h00);
      rd(8'h33, 8'h02);
      rd(8'h3c, 8'h80);
      pin_config = 2'h0;
      tick(2);
      chk_bit(irq_oe, 1'b0);
      conclude();
   end
endmodule : led_engine_status_regs_test

// >>> tb/les_host.sv
// Host model that issues byte reads and writes on the register port.
`timescale 1ns/10ps
module les_host (
   input wire logic clock,
   input wire logic engine_busy,
   input wire logic [7:0] rdata_q,
   input wire logic rvalid_q,
   output les_pkg::les_req_type req
);
   initial begin
      req = '0;
   end
   task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                         output logic [7:0] q, output logic v);
      // Start addresses are left alone while an engine clears its registers.
      while (engine_busy && a >= 8'h30 && a <= 8'h32) begin
         @(posedge clock);
      end
      @(posedge clock);
      #1 req = '{wr: w, rd: !w, addr: a, wdata: d};
      // The answer stands only in the cycle after the edge that takes the request.
      @(posedge clock);
      #1 q = rdata_q;
      v = rvalid_q;
      // Idle lines carry the inverse so a stale value never looks valid.
      req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask : access
endmodule : les_host
